// File: rtl/audio_serial_port.sv
// Full-duplex audio serial port: receive and transmit shifters with
// frame sync, word length and slot handling, plus word buffers.
// Assumes shift clocks and frame syncs come from the codec and run well
// below the system clock (at least four system cycles per half period).
// Operation
// RULE_01: Receive and transmit run independently, each with clock, frame sync, data.
// RULE_02: Separate clocks and frame syncs per direction give asynchronous mode.
// RULE_03: Synchronous mode times both directions from one clock and one frame sync.
// RULE_04: Word length selectable between 8 and 16 bits.
// RULE_05: A frame holds at most four slots, one word each.
// RULE_06: Normal mode moves exactly one word per frame each way.
// RULE_07: Network mode moves successive words into successive slots of a frame.
// RULE_08: Every frame begins at the frame sync pulse.
// RULE_09: Slot counter returns to first slot on frame sync, advances per word.
`timescale 1ns/1ps
module audio_serial_port
  import audio_serial_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic syncMode,
  input wire logic wordLen16,
  input wire logic networkMode,
  input wire logic [SLOT_BITS-1:0] lastSlot,
  input wire logic rxSclk,
  input wire logic rxFs,
  input wire logic rxSd,
  input wire logic txSclk,
  input wire logic txFs,
  output logic txSd,
  output logic [WORD_BITS-1:0] rxWord,
  output logic [SLOT_BITS-1:0] rxSlot,
  output logic rxValid,
  input wire logic rxReady,
  input wire logic [WORD_BITS-1:0] txWord,
  input wire logic txValid,
  output logic txReady,
  output logic rxOverrun,
  output logic txUnderrun
);

  typedef struct packed {
    logic [SYNC_STAGES-1:0] rxClkSync;
    logic [SYNC_STAGES-1:0] rxFsSync;
    logic [SYNC_STAGES-1:0] rxSdSync;
    logic [SYNC_STAGES-1:0] txClkSync;
    logic [SYNC_STAGES-1:0] txFsSync;
    phase_e rxPhase;
    logic [BIT_CNT_BITS-1:0] rxBit;
    logic [SLOT_BITS-1:0] rxSlot;
    logic [WORD_BITS-1:0] rxShift;
    logic rxPush;
    logic [WORD_BITS-1:0] rxPushWord;
    logic [SLOT_BITS-1:0] rxPushSlot;
    logic rxOverrun;
    phase_e txPhase;
    logic [BIT_CNT_BITS-1:0] txBit;
    logic [SLOT_BITS-1:0] txSlot;
    logic [WORD_BITS-1:0] txShift;
    logic txPop;
    logic txSd;
    logic txUnderrun;
  } state_s;

  localparam state_s STATE_RESET = '{
    rxPhase: PH_IDLE, txPhase: PH_IDLE, rxBit: BIT_CNT_RESET, txBit: BIT_CNT_RESET,
    rxSlot: SLOT_FIRST, txSlot: SLOT_FIRST, rxPushSlot: SLOT_FIRST,
    rxShift: WORD_RESET, rxPushWord: WORD_RESET, txShift: WORD_RESET,
    default: '0};

  state_s s_r;
  state_s s_nxt;

  logic rxInReady;
  logic txOutValid;
  logic [WORD_BITS-1:0] txOutWord;
  logic rxOutValid;
  logic [SLOT_BITS+WORD_BITS-1:0] rxOutData;
  logic txInReady;

  logic rxRise;
  logic txClkNow;
  logic txClkPrev;
  logic txFsNow;
  logic txRise;
  logic txFall;
  logic txLoad;
  logic [WORD_BITS-1:0] rxShifted;

  function automatic logic [BIT_CNT_BITS-1:0] lastBit(input logic long16);
    return long16 ? LAST_BIT_16 : LAST_BIT_8;
  endfunction

  // Whether another slot follows the current one in this frame
  function automatic logic moreSlots(input logic network, input logic [SLOT_BITS-1:0] slot,
                                     input logic [SLOT_BITS-1:0] last);
    return network && slot != last && slot != SLOT_LAST;
  endfunction

  always_comb begin
    s_nxt = s_r;
    // Stage 0 feeds only stage 1; stage 2 is the edge-detect history
    s_nxt.rxClkSync = {s_r.rxClkSync[1:0], rxSclk};
    s_nxt.rxFsSync = {s_r.rxFsSync[1:0], rxFs};
    s_nxt.rxSdSync = {s_r.rxSdSync[1:0], rxSd};
    s_nxt.txClkSync = {s_r.txClkSync[1:0], txSclk};
    s_nxt.txFsSync = {s_r.txFsSync[1:0], txFs};

    rxRise = s_r.rxClkSync[1] & ~s_r.rxClkSync[2]; // RULE_01
    // Shared clock and sync in synchronous mode, own pins otherwise
    txClkNow = syncMode ? s_r.rxClkSync[1] : s_r.txClkSync[1]; // RULE_02 RULE_03
    txClkPrev = syncMode ? s_r.rxClkSync[2] : s_r.txClkSync[2]; // RULE_03
    txFsNow = syncMode ? s_r.rxFsSync[1] : s_r.txFsSync[1]; // RULE_02 RULE_03
    txRise = txClkNow & ~txClkPrev;
    txFall = ~txClkNow & txClkPrev;

    // Receive: frame sync seen on a rising edge; first bit on the next one
    s_nxt.rxPush = 1'b0;
    s_nxt.rxOverrun = 1'b0;
    rxShifted = {s_r.rxShift[WORD_BITS-2:0], s_r.rxSdSync[1]};
    if (rxRise) begin
      if (s_r.rxFsSync[1]) begin
        s_nxt.rxPhase = PH_ACTIVE; // RULE_08
        s_nxt.rxBit = BIT_CNT_RESET;
        s_nxt.rxSlot = SLOT_FIRST; // RULE_09
      end else begin
        case (s_r.rxPhase)
          PH_ACTIVE: begin
            s_nxt.rxShift = rxShifted;
            if (s_r.rxBit == lastBit(wordLen16)) begin // RULE_04
              // Buffer full: word is dropped and flagged rather than stalling the link
              s_nxt.rxPush = rxInReady;
              s_nxt.rxOverrun = ~rxInReady;
              s_nxt.rxPushWord = wordLen16 ? rxShifted : {8'h00, rxShifted[7:0]}; // RULE_04
              s_nxt.rxPushSlot = s_r.rxSlot;
              s_nxt.rxBit = BIT_CNT_RESET;
              if (moreSlots(networkMode, s_r.rxSlot, lastSlot)) begin // RULE_05 RULE_07
                s_nxt.rxSlot = s_r.rxSlot + 2'h1; // RULE_09
              end else begin
                s_nxt.rxPhase = PH_IDLE; // RULE_06
              end
            end else begin
              s_nxt.rxBit = s_r.rxBit + 4'h1;
            end
          end
          default: begin
            s_nxt.rxPhase = PH_IDLE;
          end
        endcase
      end
    end

    // Transmit: load on frame sync, shift out MSB first on falling edges
    s_nxt.txPop = 1'b0;
    s_nxt.txUnderrun = 1'b0;
    txLoad = 1'b0;
    if (txRise && txFsNow) begin
      s_nxt.txPhase = PH_ACTIVE; // RULE_08
      s_nxt.txBit = BIT_CNT_RESET;
      s_nxt.txSlot = SLOT_FIRST; // RULE_09
      txLoad = 1'b1;
    end else if (txFall) begin
      case (s_r.txPhase)
        PH_ACTIVE: begin
          s_nxt.txSd = wordLen16 ? s_r.txShift[15] : s_r.txShift[7]; // RULE_04
          s_nxt.txShift = {s_r.txShift[WORD_BITS-2:0], 1'b0};
          if (s_r.txBit == lastBit(wordLen16)) begin
            s_nxt.txBit = BIT_CNT_RESET;
            if (moreSlots(networkMode, s_r.txSlot, lastSlot)) begin // RULE_05 RULE_07
              s_nxt.txSlot = s_r.txSlot + 2'h1; // RULE_09
              txLoad = 1'b1;
            end else begin
              s_nxt.txPhase = PH_IDLE; // RULE_06
            end
          end else begin
            s_nxt.txBit = s_r.txBit + 4'h1;
          end
        end
        default: begin
          s_nxt.txSd = 1'b0;
        end
      endcase
    end
    // Empty buffer: send silence so frame timing is never disturbed
    if (txLoad) begin
      if (txOutValid) begin
        s_nxt.txShift = txOutWord;
        s_nxt.txPop = 1'b1;
      end else begin
        s_nxt.txShift = WORD_RESET;
        s_nxt.txUnderrun = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  slot_fifo #(
    .WIDTH(SLOT_BITS + WORD_BITS),
    .DEPTH(DEPTH)
  ) rxBuf (
    .clk(clk),
    .rstn(rstn),
    .inValid(s_r.rxPush),
    .inReady(rxInReady),
    .inData({s_r.rxPushSlot, s_r.rxPushWord}),
    .outValid(rxOutValid),
    .outReady(rxReady),
    .outData(rxOutData)
  );

  slot_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(DEPTH)
  ) txBuf (
    .clk(clk),
    .rstn(rstn),
    .inValid(txValid),
    .inReady(txInReady),
    .inData(txWord),
    .outValid(txOutValid),
    .outReady(s_r.txPop),
    .outData(txOutWord)
  );

  assign txSd = s_r.txSd;
  assign rxOverrun = s_r.rxOverrun;
  assign txUnderrun = s_r.txUnderrun;
  assign rxValid = rxOutValid;
  assign rxWord = rxOutData[WORD_BITS-1:0];
  assign rxSlot = rxOutData[SLOT_BITS+WORD_BITS-1:WORD_BITS];
  assign txReady = txInReady;

endmodule

// File: shared/audio_serial_pkg.sv
// Constants and types shared by the audio serial port and its buffer.
// Assumes a single system clock; the link pins are foreign to it.
package audio_serial_pkg;

  localparam int WORD_BITS = 16;
  localparam int SLOT_BITS = 2;
  localparam int BIT_CNT_BITS = 4;
  localparam int SYNC_STAGES = 3;
  localparam int BUF_DEPTH = 2;
  localparam int SLOTS_MAX = 4;

  localparam logic [BIT_CNT_BITS-1:0] LAST_BIT_16 = 4'hf;
  localparam logic [BIT_CNT_BITS-1:0] LAST_BIT_8 = 4'h7;
  localparam logic [BIT_CNT_BITS-1:0] BIT_CNT_RESET = 4'h0;
  localparam logic [SLOT_BITS-1:0] SLOT_FIRST = 2'h0;
  localparam logic [SLOT_BITS-1:0] SLOT_LAST = 2'h3;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;

  typedef enum logic {PH_IDLE, PH_ACTIVE} phase_e;

endpackage

// File: rtl/slot_fifo.sv
// Small shift-register FIFO with valid/ready on both sides.
// Head entry is a flop, so the read side sees registered data and flags.
`timescale 1ns/1ps
module slot_fifo
  import audio_serial_pkg::*;
#(
  parameter int WIDTH = WORD_BITS,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] ONE = CW'(1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] data;
    logic [CW-1:0] count;
    logic inReady;
    logic outValid;
  } buf_s;

  localparam buf_s BUF_RESET = '{data: '0, count: '0, inReady: 1'b1, outValid: 1'b0};

  buf_s s_r;
  buf_s s_nxt;
  logic push;
  logic pop;
  logic [CW-1:0] wrIdx;

  always_comb begin
    s_nxt = s_r;
    push = inValid & s_r.inReady;
    pop = outReady & s_r.outValid;
    wrIdx = pop ? s_r.count - ONE : s_r.count;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        s_nxt.data[i] = s_r.data[i+1];
      end
    end
    if (push) begin
      s_nxt.data[wrIdx] = inData;
    end
    if (push && !pop) begin
      s_nxt.count = s_r.count + ONE;
    end else if (pop && !push) begin
      s_nxt.count = s_r.count - ONE;
    end
    // Flags precomputed so both ready and valid leave from flops
    s_nxt.outValid = s_nxt.count != '0;
    s_nxt.inReady = s_nxt.count != FULL;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= BUF_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign inReady = s_r.inReady;
  assign outValid = s_r.outValid;
  assign outData = s_r.data[0];

endmodule

// File: test/codec_model.sv
// Codec stand-in: makes shift clock and frame sync, sends and captures words.
// Assumes the bench calls frame() just after a system clock edge.
`timescale 1ns/1ps
module codec_model (
  output logic sclk,
  output logic fs,
  output logic sd,
  input wire logic din
);
  initial begin
    sclk = 1'b0;
    fs = 1'b0;
    sd = 1'b0;
  end
  // Clock stands still low between frames
  task automatic frame(input int n, input int nb, input logic [15:0] w [4],
                       output logic [15:0] q [4]);
    q = '{default: 16'h0000};
    for (int i = -1; i < n * nb; i++) begin
      fs = (i < 0);
      sd = (i < 0) ? ~sd : w[i / nb][nb - 1 - i % nb];
      #40 sclk = 1'b1;
      if (i >= 0) q[i / nb][nb - 1 - i % nb] = din;
      #40 sclk = 1'b0;
    end
    fs = 1'b0;
    sd = ~sd; // Released line shows no stale level
  endtask
endmodule

// File: test/audio_serial_port_sva.sv
// Checks on the audio serial port's pins and user handshakes.
// Sees only top module ports; bound at the foot of this file.
`timescale 1ns/1ps
module audio_serial_port_sva
  import audio_serial_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic syncMode,
  input wire logic wordLen16,
  input wire logic networkMode,
  input wire logic [SLOT_BITS-1:0] lastSlot,
  input wire logic rxSclk,
  input wire logic txSclk,
  input wire logic txSd,
  input wire logic [WORD_BITS-1:0] rxWord,
  input wire logic [SLOT_BITS-1:0] rxSlot,
  input wire logic rxValid,
  input wire logic rxReady,
  input wire logic txReady,
  input wire logic rxOverrun,
  input wire logic txUnderrun
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence rx_stall;
    rxValid && !rxReady;
  endsequence
  sequence tx_edge;
    $changed(txSd);
  endsequence
  reset_out_a:
    assert property ($rose(rstn) |-> !rxValid && txReady && rxSlot == SLOT_FIRST)
    else $error("bad outputs after reset");
  rx_hold_a:
    assert property (rx_stall |=> rxValid && $stable(rxWord) && $stable(rxSlot))
    else $error("stalled word changed");
  normal_slot_a:
    assert property (rxValid && !networkMode |-> rxSlot == SLOT_FIRST)
    else $error("normal mode slot not first");
  slot_max_a:
    assert property (rxValid && networkMode |-> rxSlot <= lastSlot)
    else $error("slot past last slot");
  byte_upper_a:
    assert property (rxValid && !wordLen16 |-> rxWord[15:8] == 8'h00)
    else $error("short word upper byte set");
  overrun_pulse_a:
    assert property (rxOverrun |-> rxValid ##1 !rxOverrun)
    else $error("overrun without full buffer");
  underrun_pulse_a:
    assert property (txUnderrun |-> txReady ##1 !txUnderrun)
    else $error("underrun with words held");
  sync_edge_a:
    assert property (syncMode ##0 tx_edge |-> !rxSclk)
    else $error("tx data moved off shared falling edge");
  async_edge_a:
    assert property (!syncMode ##0 tx_edge |-> !txSclk)
    else $error("tx data moved off own falling edge");
endmodule

bind audio_serial_port audio_serial_port_sva #(.DEPTH(DEPTH)) chk (.clk, .rstn,
  .syncMode, .wordLen16, .networkMode, .lastSlot, .rxSclk, .txSclk, .txSd, .rxWord,
  .rxSlot, .rxValid, .rxReady, .txReady, .rxOverrun, .txUnderrun);

// File: test/tb_audio_serial_port.sv
// Self-checking bench: table of frame formats, then overrun and fill cases.
// Assumes the codec model is the only source of link pin activity.
`timescale 1ns/1ps
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin nMismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_audio_serial_port;
  import audio_serial_pkg::*;
  typedef struct {logic sm, w16, net; logic [1:0] last; int n;} row_s;
  row_s rows [4] = '{'{0, 1, 0, 0, 1}, '{1, 0, 0, 0, 1}, '{1, 1, 1, 3, 4}, '{0, 0, 1, 1, 2}};
  logic clk = 1'b0, rstn = 1'b0, syncMode = 1'b0, wordLen16 = 1'b0, networkMode = 1'b0;
  logic sclk, fs, rxSd, txSd, rxValid, rxReady = 1'b1, txValid = 1'b0, txReady;
  logic sclkT, fsT;
  logic rxOverrun, txUnderrun;
  logic [1:0] lastSlot = 2'h0, rxSlot;
  logic [15:0] rxWord, txWord = 16'h0000;
  logic [15:0] w [4], q [4], qT [4];
  int nMismatch = 0, totalChecks = 0, nOvr = 0, nUnd = 0;
  always #2.5 clk = ~clk;
  // Counted on the falling edge, away from the edge that launches the pulses
  always @(negedge clk) begin
    nOvr += (rxOverrun === 1'b1);
    nUnd += (txUnderrun === 1'b1);
  end
  audio_serial_port DUT (.clk, .rstn, .syncMode, .wordLen16, .networkMode, .lastSlot,
    .rxSclk(sclk), .rxFs(fs), .rxSd, .txSclk(sclkT), .txFs(fsT), .txSd, .rxWord, .rxSlot,
    .rxValid, .rxReady, .txWord, .txValid, .txReady, .rxOverrun, .txUnderrun);
  codec_model codec (.sclk, .fs, .sd(rxSd), .din(txSd));
  // Own tx clock runs one bit late, so a path on the wrong clock shifts every bit
  codec_model codecTx (.sclk(sclkT), .fs(fsT), .sd(), .din(txSd));
  task automatic give_verdict();
    if (nMismatch == 0 && totalChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic guard(input logic ok);
    if (ok !== 1'b1) begin
      nMismatch++;
      give_verdict();
    end
  endtask
  // Holds valid high between words so it is never set twice in one step
  task automatic push(input logic [15:0] d);
    txWord = d;
    txValid = 1'b1;
    for (int k = 0; k < 2000 && txReady !== 1'b1; k++) tick();
    guard(txReady);
    tick();
  endtask
  task automatic pull(input logic [15:0] e, input logic [1:0] s);
    for (int k = 0; k < 3000 && rxValid !== 1'b1; k++) tick();
    guard(rxValid);
    `CHK(rxWord, e)
    `CHK(rxSlot, s)
    tick();
  endtask
  // One frame plus, when it has fewer than four slots, a spare slot past the last one, which must be ignored
  task automatic run(input row_s r, input bit feed);
    int nb;
    logic [15:0] m;
    nb = r.w16 ? 16 : 8;
    m = r.w16 ? 16'hffff : 16'h00ff;
    syncMode = r.sm;
    wordLen16 = r.w16;
    networkMode = r.net;
    lastSlot = r.last;
    for (int j = 0; j < 4; j++) w[j] = (16'h9c35 + 16'h2f1b * 16'(j)) & m;
    fork
      codec.frame(r.n + (r.n < 4), nb, w, q);
      if (!r.sm) begin
        #80;
        codecTx.frame(r.n + (r.n < 4), nb, w, qT);
      end
      if (feed) begin
        for (int j = 0; j < r.n; j++) push(~w[j]);
        txValid = 1'b0;
      end
      if (rxReady) for (int j = 0; j < r.n; j++) pull(w[j], r.net ? 2'(j) : 2'h0);
    join
    // Tx words come back on the tx clock's model in asynchronous mode
    if (!r.sm) q = qT;
    repeat (10) tick();
    `CHK(rxValid, ~rxReady)
    for (int j = 0; j < r.n; j++) `CHK(q[j], feed ? ~w[j] & m : 16'h0000)
    if (r.n < 4) `CHK(q[r.n], 16'h0000)
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    tick();
    `CHK(txReady, 1'b1)
    `CHK(rxValid, 1'b0)
    `CHK(txSd, 1'b0)
    for (int i = 0; i < 4; i++) run(rows[i], 1'b1);
    // Receiver stalls and no words offered: drops and zeros expected
    rxReady = 1'b0;
    run(rows[2], 1'b0);
    `CHK(nOvr, 2)
    `CHK(nUnd, 4)
    rxReady = 1'b1;
    pull(w[0], 2'h0);
    pull(w[1], 2'h1);
    push(16'h1234);
    push(16'h5678);
    `CHK(txReady, 1'b0)
    txValid = 1'b0;
    // Reset in mid-run must empty the full transmit buffer
    rstn = 1'b0;
    tick();
    rstn = 1'b1;
    tick();
    `CHK(txReady, 1'b1)
    `CHK(rxValid, 1'b0)
    `CHK(txSd, 1'b0)
    give_verdict();
  end
endmodule
